// [inc/sink_training_defines.svh]
// Register offsets, field positions and reset values of the training block.
`ifndef SINK_TRAINING_DEFINES_SVH
`define SINK_TRAINING_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_SWING_POLICY 12'h214
`define OFS_LOCK_CONTROL 12'h21c
`define OFS_IDLE_PERIOD 12'h220
`define OFS_STATUS 12'h224
`define ADDR_W 12

// ****************************************************************
// Fields of training_swing_policy
// ****************************************************************
`define MIN_SWING_LO 0
`define MIN_SWING_HI 1
`define CR_OPT_LO 2
`define CR_OPT_HI 3
`define STEP_LO 4
`define STEP_HI 6
`define FIX_SWING_LO 8
`define FIX_SWING_HI 9
`define EQ_OPT_LO 10
`define EQ_OPT_HI 11
`define EMPH_LIM_LO 12
`define EMPH_LIM_HI 13
`define TABLE_LO 14
`define TABLE_HI 23
`define POLICY_RESET 32'h0000_0000
`define POLICY_MASK 32'h00ff_ff7f

// ****************************************************************
// Fields of recovery_lock_control and unplug_idle_period
// ****************************************************************
`define LOCK_TMO_LO 0
`define LOCK_TMO_HI 19
`define DFE_BIT 31
`define LOCK_RESET 32'h8000_1388
`define LOCK_MASK 32'h800f_ffff
`define IDLE_RESET 32'h0131_2d00

// ****************************************************************
// Option codes and levels
// ****************************************************************
`define CR_EVERY 2'h0
`define CR_BLOCK 2'h1
`define CR_FIXED 2'h2
`define EQ_STEP 2'h0
`define EQ_FIXED 2'h1
`define EQ_TABLE 2'h3
`define LEVEL_MAX 2'h3
`define BLOCK_DEFAULT 3'h4
`define TABLE_LAST 3'h4

`endif

// [inc/sink_training_pkg.sv]
// Types shared by the sink training and unplug timer block.

package sink_training_pkg;

    // Lock timer states.
    typedef enum logic [1:0] {
        LOCK_IDLE = 2'b00,
        LOCK_WAIT = 2'b01,
        LOCK_DONE = 2'b10,
        LOCK_TIMEOUT = 2'b11
    } lock_state_type;

    // Complete state of the block.
    typedef struct packed {
        logic [31:0] policy;
        logic [31:0] lock_ctl;
        logic [31:0] idle;
        logic ack;
        logic [31:0] rdata;
        logic [2:0] clk_sync;
        logic [1:0] bs_sync;
        logic [1:0] tp_sync;
        logic [1:0] lock_sync;
        logic [1:0] swing;
        logic [1:0] emph;
        logic [2:0] step_cnt;
        logic [2:0] emph_idx;
        logic fail;
        lock_state_type lock_state;
        logic [19:0] lock_cnt;
        logic [31:0] idle_cnt;
        logic armed;
        logic unplug;
        logic dfe;
    } state_type;

endpackage : sink_training_pkg

// [rtl/sink_training_ctrl.sv]
// Sink training policy, recovery lock timer and cable unplug detector.
//
// Overview of operation
// - Report training failure while any lane swing low
// - Default option raises swing every iteration
// - Second option raises swing once per block
// - Third option holds swing at fixed level
// - Three-bit field sets iterations between swing steps
// - Fixed swing level field resets to zero
// - Default option raises emphasis up to limit
// - Second option holds emphasis at limit value
// - Fourth option takes emphasis from table
// - Two-bit field holds emphasis limit level
// - Table holds five levels, iteration one lowest
// - Twenty-bit lock timeout counter, resets 20'h1388
// - Equalizer enable bit resets one, only 5.4G
// - Missing blanking-start within period raises unplug
// - Unplug counter loads from idle period register
// - Idle period resets to 0x1312d00
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "sink_training_defines.svh"

module sink_training_ctrl #(
    parameter int LANES = 4
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Training iteration events from the training engine.
    input wire logic train_start_i,
    input wire logic cr_iter_i,
    input wire logic eq_iter_i,
    input wire logic [2*LANES-1:0] lane_swing_i,
    output logic [1:0] swing_req_o,
    output logic [1:0] emph_req_o,
    output logic train_fail_o,
    // Recovery lock timer.
    input wire logic lock_start_i,
    input wire logic cdr_lock_i,
    input wire logic rate_5g4_i,
    output logic lock_timeout_o,
    output logic dfe_enable_o,
    // Link symbol indications, synchronised to clk_i; blank start taken at link clock rising edges.
    input wire logic link_clk_i,
    input wire logic blank_start_i,
    input wire logic training_pattern_i,
    output logic unplug_o
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************

    // The lane count must fit the standard one to four lanes.
    if (LANES < 1 || LANES > 4) begin : bad_lanes
        $error("LANES must be between 1 and 4.");
    end

    // ****************************************************************
    // State and helpers
    // ****************************************************************

    sink_training_pkg::state_type s;
    sink_training_pkg::state_type next_s;
    logic access;
    logic link_edge;
    logic bs_seen;
    logic tp_seen;
    logic low_swing;
    logic [2:0] block_len;
    logic [31:0] status_word;

    // Merge write data into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] sel,
                                          input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res & mask;
    endfunction : merge

    // Pick one level of the per-iteration emphasis table.
    function automatic logic [1:0] table_level(input logic [31:0] pol,
                                               input logic [2:0] idx);
        logic [9:0] tbl;
        logic [1:0] lvl;
        tbl = pol[`TABLE_HI:`TABLE_LO];
        case (idx)
            3'h0: lvl = tbl[1:0]; // Iteration one in the lowest pair.
            3'h1: lvl = tbl[3:2];
            3'h2: lvl = tbl[5:4];
            3'h3: lvl = tbl[7:6];
            default: lvl = tbl[9:8]; // Iteration five at the top.
        endcase
        return lvl;
    endfunction : table_level

    // ****************************************************************
    // Combinational decodes
    // ****************************************************************

    // Bus access is taken once, in the cycle the answer is given.
    assign access = wb_cyc_i && wb_stb_i && s.ack;

    // Link clock rising edge seen through the synchroniser.
    assign link_edge = s.clk_sync[1] && !s.clk_sync[2];
    assign bs_seen = link_edge && s.bs_sync[1];
    assign tp_seen = s.tp_sync[1];

    // Steps between swing increments; zero falls back to four.
    assign block_len = (s.policy[`STEP_HI:`STEP_LO] == 3'h0) ?
                       `BLOCK_DEFAULT : s.policy[`STEP_HI:`STEP_LO];

    // Any lane below the programmed minimum swing fails training.
    always_comb begin
        low_swing = 1'b0;
        for (int l = 0; l < LANES; l++) begin
            if (lane_swing_i[2*l +: 2] <
                s.policy[`MIN_SWING_HI:`MIN_SWING_LO]) begin
                low_swing = 1'b1;
            end
        end
    end

    // Status word: requests, failure, lock state and unplug pulse.
    assign status_word = {24'h000000, s.unplug, s.lock_state, s.fail,
                          s.emph, s.swing};

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Compute the whole next state from the current one.
    always_comb begin
        next_s = s;

        // Synchronisers for signals from outside this clock domain.
        next_s.clk_sync = {s.clk_sync[1:0], link_clk_i};
        next_s.bs_sync = {s.bs_sync[0], blank_start_i};
        next_s.tp_sync = {s.tp_sync[0], training_pattern_i};
        next_s.lock_sync = {s.lock_sync[0], cdr_lock_i};

        // Wishbone answer one cycle after the request, dropped next cycle.
        next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            if (wb_adr_i == `OFS_SWING_POLICY) begin
                next_s.rdata = s.policy;
            end else if (wb_adr_i == `OFS_LOCK_CONTROL) begin
                next_s.rdata = s.lock_ctl;
            end else if (wb_adr_i == `OFS_IDLE_PERIOD) begin
                next_s.rdata = s.idle;
            end else if (wb_adr_i == `OFS_STATUS) begin
                next_s.rdata = status_word;
            end else begin
                next_s.rdata = 32'h0000_0000;
            end
        end

        // Register writes take effect at the acknowledging edge.
        if (access && wb_we_i) begin
            if (wb_adr_i == `OFS_SWING_POLICY) begin
                next_s.policy = merge(s.policy, wb_dat_i, wb_sel_i,
                                      `POLICY_MASK);
            end else if (wb_adr_i == `OFS_LOCK_CONTROL) begin
                next_s.lock_ctl = merge(s.lock_ctl, wb_dat_i, wb_sel_i,
                                        `LOCK_MASK);
            end else if (wb_adr_i == `OFS_IDLE_PERIOD) begin
                next_s.idle = merge(s.idle, wb_dat_i, wb_sel_i,
                                    32'hffff_ffff);
            end
        end

        // Training failure follows the lane swing comparison.
        next_s.fail = low_swing;

        // Swing request policy on clock recovery iterations.
        if (train_start_i) begin
            next_s.step_cnt = 3'h0;
            if (s.policy[`CR_OPT_HI:`CR_OPT_LO] == `CR_FIXED) begin
                next_s.swing = s.policy[`FIX_SWING_HI:`FIX_SWING_LO];
            end else begin
                next_s.swing = 2'h0;
            end
        end else if (cr_iter_i) begin
            case (s.policy[`CR_OPT_HI:`CR_OPT_LO])
                `CR_BLOCK: begin
                    if (s.step_cnt + 3'h1 >= block_len) begin
                        next_s.step_cnt = 3'h0;
                        if (s.swing != `LEVEL_MAX) begin
                            next_s.swing = s.swing + 2'h1;
                        end
                    end else begin
                        next_s.step_cnt = s.step_cnt + 3'h1;
                    end
                end
                `CR_FIXED: begin
                    next_s.swing = s.policy[`FIX_SWING_HI:`FIX_SWING_LO];
                end
                default: begin
                    // The default and the invalid code step every time.
                    if (s.swing != `LEVEL_MAX) begin
                        next_s.swing = s.swing + 2'h1;
                    end
                end
            endcase
        end

        // Emphasis request policy on equalisation iterations.
        if (train_start_i) begin
            next_s.emph_idx = 3'h0;
            case (s.policy[`EQ_OPT_HI:`EQ_OPT_LO])
                `EQ_FIXED: next_s.emph = s.policy[`EMPH_LIM_HI:`EMPH_LIM_LO];
                `EQ_TABLE: next_s.emph = table_level(s.policy, 3'h0);
                default: next_s.emph = 2'h0;
            endcase
        end else if (eq_iter_i) begin
            case (s.policy[`EQ_OPT_HI:`EQ_OPT_LO])
                `EQ_FIXED: begin
                    next_s.emph = s.policy[`EMPH_LIM_HI:`EMPH_LIM_LO];
                end
                `EQ_TABLE: begin
                    if (s.emph_idx != `TABLE_LAST) begin
                        next_s.emph_idx = s.emph_idx + 3'h1;
                        next_s.emph = table_level(s.policy,
                                                  s.emph_idx + 3'h1);
                    end
                end
                default: begin
                    // The default and the invalid code climb to the limit.
                    if (s.emph < s.policy[`EMPH_LIM_HI:`EMPH_LIM_LO]) begin
                        next_s.emph = s.emph + 2'h1;
                    end
                end
            endcase
        end

        // Recovery lock timer on this clock, loaded from the register.
        case (s.lock_state)
            sink_training_pkg::LOCK_IDLE: begin
                if (lock_start_i) begin
                    next_s.lock_cnt = s.lock_ctl[`LOCK_TMO_HI:`LOCK_TMO_LO];
                    next_s.lock_state = sink_training_pkg::LOCK_WAIT;
                end
            end
            sink_training_pkg::LOCK_WAIT: begin
                if (s.lock_sync[1]) begin
                    next_s.lock_state = sink_training_pkg::LOCK_DONE;
                end else if (s.lock_cnt == 20'h00000) begin
                    next_s.lock_state = sink_training_pkg::LOCK_TIMEOUT;
                end else begin
                    next_s.lock_cnt = s.lock_cnt - 20'h00001;
                end
            end
            default: begin
                // Done or timed out: wait for the next start.
                if (lock_start_i) begin
                    next_s.lock_cnt = s.lock_ctl[`LOCK_TMO_HI:`LOCK_TMO_LO];
                    next_s.lock_state = sink_training_pkg::LOCK_WAIT;
                end
            end
        endcase

        // Equalizer enable only applies at the 5.4G rate.
        next_s.dfe = s.lock_ctl[`DFE_BIT] && rate_5g4_i;

        // Unplug timer: reload on blanking start or while training.
        next_s.unplug = 1'b0;
        if (bs_seen || tp_seen) begin
            next_s.idle_cnt = s.idle;
            next_s.armed = bs_seen || s.armed;
        end else if (s.armed) begin
            if (s.idle_cnt <= 32'h0000_0001) begin
                next_s.unplug = 1'b1;
                next_s.armed = 1'b0;
                next_s.idle_cnt = s.idle;
            end else begin
                next_s.idle_cnt = s.idle_cnt - 32'h0000_0001;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Register the state; reset puts every field at its reset value.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.policy <= `POLICY_RESET;
            s.lock_ctl <= `LOCK_RESET;
            s.idle <= `IDLE_RESET;
            s.idle_cnt <= `IDLE_RESET;
            s.lock_state <= sink_training_pkg::LOCK_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Outputs come straight from the state register; lock_timeout_o is decoded from the lock state.
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
    assign swing_req_o = s.swing;
    assign emph_req_o = s.emph;
    assign train_fail_o = s.fail;
    assign lock_timeout_o = (s.lock_state == sink_training_pkg::LOCK_TIMEOUT);
    assign dfe_enable_o = s.dfe;
    assign unplug_o = s.unplug;

endmodule : sink_training_ctrl

// [bench/sink_training_chk.sv]
// Port checker of the sink training and unplug timer block.
`timescale 1ns/1ps
`include "sink_training_defines.svh"

module sink_training_chk #(
    parameter int LANES = 4
) (
    // Clock, reset and bus.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Training.
    input wire logic train_start_i,
    input wire logic cr_iter_i,
    input wire logic eq_iter_i,
    input wire logic [2*LANES-1:0] lane_swing_i,
    input wire logic [1:0] swing_req_o,
    input wire logic [1:0] emph_req_o,
    input wire logic train_fail_o,
    // Lock, equaliser and unplug.
    input wire logic lock_start_i,
    input wire logic rate_5g4_i,
    input wire logic lock_timeout_o,
    input wire logic dfe_enable_o,
    input wire logic unplug_o
);
    typedef struct packed {
        logic [31:0] pol;
        logic dfe;
    } shadow_type;
    shadow_type sh;
    shadow_type next_sh;
    logic low;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Shadow of the policy and equaliser bit, taken at acknowledged writes.
    always_comb begin
        next_sh = sh;
        if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
            if (wb_adr_i == `OFS_SWING_POLICY)
                next_sh.pol = wb_dat_i & 32'h00ff_ff7f;
            if (wb_adr_i == `OFS_LOCK_CONTROL)
                next_sh.dfe = wb_dat_i[31];
        end
    end

    // Registers the shadow copy.
    always_ff @(posedge clk_i) begin
        if (rst_i)
            sh <= '{pol: 32'h0000_0000, dfe: 1'b1};
        else
            sh <= next_sh;
    end

    // High while some lane swing is under the programmed minimum.
    always_comb begin
        low = 1'b0;
        for (int l = 0; l < LANES; l++) begin
            if (lane_swing_i[2*l +: 2] < sh.pol[1:0])
                low = 1'b1;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_bus_answer: assert property (s_req |=> s_ack)
        else $error("bus answer not a one-cycle ack");
    a_fail_min: assert property (!$past(rst_i) |->
        train_fail_o == $past(low)) else $error("fail flag wrong");
    a_dfe_rate: assert property (!$past(rst_i) |->
        dfe_enable_o == $past(sh.dfe && rate_5g4_i))
        else $error("equaliser enable wrong");
    a_cr_every: assert property (cr_iter_i && !train_start_i &&
        sh.pol[3:2] != 2'h1 && sh.pol[3:2] != 2'h2 && swing_req_o != 2'h3
        |=> swing_req_o == $past(swing_req_o) + 2'h1)
        else $error("swing did not step");
    a_cr_fixed: assert property ((cr_iter_i || train_start_i) &&
        sh.pol[3:2] == 2'h2 |=> swing_req_o == $past(sh.pol[9:8]))
        else $error("swing not held at fixed level");
    a_emph_step: assert property (eq_iter_i && !train_start_i &&
        sh.pol[11:10] != 2'h1 && sh.pol[11:10] != 2'h3 &&
        emph_req_o < sh.pol[13:12]
        |=> emph_req_o == $past(emph_req_o) + 2'h1)
        else $error("emphasis did not step");
    a_emph_fixed: assert property ((eq_iter_i || train_start_i) &&
        sh.pol[11:10] == 2'h1 |=> emph_req_o == $past(sh.pol[13:12]))
        else $error("emphasis not held at limit");
    a_emph_table: assert property (train_start_i &&
        sh.pol[11:10] == 2'h3 |=> emph_req_o == $past(sh.pol[15:14]))
        else $error("emphasis not first table entry");
    a_lock_hold: assert property (lock_timeout_o && !lock_start_i
        |=> lock_timeout_o) else $error("timeout flag dropped");
    a_unplug_pulse: assert property (unplug_o |=> !unplug_o)
        else $error("unplug longer than one cycle");
endmodule : sink_training_chk

bind sink_training_ctrl sink_training_chk #(.LANES(LANES)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .train_start_i(train_start_i), .cr_iter_i(cr_iter_i),
    .eq_iter_i(eq_iter_i), .lane_swing_i(lane_swing_i),
    .swing_req_o(swing_req_o), .emph_req_o(emph_req_o),
    .train_fail_o(train_fail_o), .lock_start_i(lock_start_i),
    .rate_5g4_i(rate_5g4_i), .lock_timeout_o(lock_timeout_o),
    .dfe_enable_o(dfe_enable_o), .unplug_o(unplug_o)
);

// [bench/link_source_model.sv]
// Behavioural link source facing the sink block.
`timescale 1ns/1ps

module link_source_model #(
    parameter int LANES = 4
) (
    // Commands from the bench.
    input wire logic active_i,
    input wire logic send_bs_i,
    input wire logic send_tp_i,
    input wire logic drop_i,
    input wire logic [1:0] swing_req_i,
    // Link side.
    output logic link_clk_o,
    output logic blank_start_o,
    output logic training_pattern_o,
    output logic [2*LANES-1:0] lane_swing_o
);
    logic phase = 1'b0;

    // Link clock runs only while active and stands low otherwise.
    initial link_clk_o = 1'b0;
    always begin
        #62.5;
        link_clk_o = active_i ? !link_clk_o : 1'b0;
    end

    // One symbol every second link period, none while training.
    initial blank_start_o = 1'b0;
    always @(negedge link_clk_o or negedge active_i) begin
        phase <= !phase;
        blank_start_o <= send_bs_i && !send_tp_i && active_i && !phase;
    end

    // The source follows the sink request; lane 0 may be held at zero.
    assign training_pattern_o = send_tp_i;
    assign lane_swing_o = {{(LANES-1){swing_req_i}},
        drop_i ? 2'h0 : swing_req_i};
endmodule : link_source_model

// [bench/sink_training_ctrl_tb.sv]
// Self-checking bench of the sink training and unplug timer block.
`timescale 1ns/1ps
`include "sink_training_defines.svh"

module sink_training_ctrl_tb;
    localparam int LANES = 4;
    localparam int N = 16;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic tstart = 1'b0, cri = 1'b0, eqi = 1'b0, lstart = 1'b0;
    logic lock = 1'b0, rate = 1'b0, act = 1'b0, sbs = 1'b0;
    logic stp = 1'b0, drop = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, pol, seed = 32'h6052b0a4;
    logic ack, fail, lto, dfe, unp, lclk, bs, tp;
    logic [1:0] swr, emr, k, es, ee;
    logic [3:0] n4;
    logic [7:0] lsw;
    logic [31:0] expq[$];
    int num_errors = 0, n_checks = 0, nunp = 0, n;
    // Policy, iterations, event kind, expected swing and emphasis.
    logic [41:0] tbl [12] = '{
        {32'h0, 4'h4, 2'h1, 2'h3, 2'h0}, {32'h4, 4'h3, 2'h1, 2'h0, 2'h0},
        {32'h4, 4'h8, 2'h1, 2'h2, 2'h0}, {32'h24, 4'h5, 2'h1, 2'h2, 2'h0},
        {32'h208, 4'h3, 2'h1, 2'h2, 2'h0}, {32'hc, 4'h2, 2'h1, 2'h2, 2'h0},
        {32'h2000, 4'h3, 2'h2, 2'h0, 2'h2}, {32'h3400, 4'h2, 2'h2, 2'h0, 2'h3},
        {32'h3800, 4'h2, 2'h2, 2'h0, 2'h2}, {32'hcb4c00, 4'h0, 2'h2, 2'h0, 2'h1},
        {32'hcb4c00, 4'h2, 2'h2, 2'h0, 2'h2}, {32'hcb4c00, 4'h6, 2'h2, 2'h0, 2'h3}};

    always #2.5 clk = !clk;

    sink_training_ctrl #(.LANES(LANES)) u_dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .train_start_i(tstart),
        .cr_iter_i(cri), .eq_iter_i(eqi), .lane_swing_i(lsw),
        .swing_req_o(swr), .emph_req_o(emr), .train_fail_o(fail),
        .lock_start_i(lstart), .cdr_lock_i(lock), .rate_5g4_i(rate),
        .lock_timeout_o(lto), .dfe_enable_o(dfe), .link_clk_i(lclk),
        .blank_start_i(bs), .training_pattern_i(tp), .unplug_o(unp));
    link_source_model #(.LANES(LANES)) u_src (
        .active_i(act), .send_bs_i(sbs), .send_tp_i(stp), .drop_i(drop),
        .swing_req_i(swr), .link_clk_o(lclk), .blank_start_o(bs),
        .training_pattern_o(tp), .lane_swing_o(lsw));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic expire(input int c, input int lim);
        if (c >= lim) begin
            num_errors++;
            $display("[FAIL] wait expected done seen timeout");
            give_verdict();
        end
    endtask : expire
    // One classic cycle, held until ack is sampled high.
    task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
        int c;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (ack !== 1'b1 && c < 20);
        expire(c, 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic rd(logic [11:0] a, logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // Pulses start, clock recovery, equalisation or lock start c times.
    task automatic ev(input int kind, input int c);
        repeat (c) begin
            @(posedge clk);
            tstart <= (kind == 0);
            cri <= (kind == 1);
            eqi <= (kind == 2);
            lstart <= (kind == 3);
            @(posedge clk);
            {tstart, cri, eqi, lstart} <= 4'h0;
        end
        repeat (2) @(posedge clk);
    endtask : ev

    // Read data is compared against the oldest expectation.
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0)
            check("read data", expq.pop_front(), rdat);
        if (unp === 1'b1)
            nunp++;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_SWING_POLICY, 32'h0);
        rd(`OFS_LOCK_CONTROL, 32'h8000_1388);
        rd(`OFS_IDLE_PERIOD, 32'h0131_2d00);
        rd(12'h100, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(lfsr(lfsr(seed)));
            bus(1'b1, `OFS_SWING_POLICY, seed);
            rd(`OFS_SWING_POLICY, seed & 32'h00ff_ff7f);
            bus(1'b1, `OFS_LOCK_CONTROL, seed);
            rd(`OFS_LOCK_CONTROL, seed & 32'h800f_ffff);
        end
        $display("test registers done");
        foreach (tbl[i]) begin
            {pol, n4, k, es, ee} = tbl[i];
            bus(1'b1, `OFS_SWING_POLICY, pol);
            ev(0, 1);
            ev(k, n4);
            check("swing", es, swr);
            check("emphasis", ee, emr);
        end
        $display("test adjust policies done");
        bus(1'b1, `OFS_SWING_POLICY, 32'h2);
        ev(0, 1);
        check("fail low", 1, fail);
        ev(1, 2);
        check("fail met", 0, fail);
        drop <= 1'b1;
        repeat (3) @(posedge clk);
        check("fail one lane", 1, fail);
        drop <= 1'b0;
        $display("test minimum swing done");
        bus(1'b1, `OFS_LOCK_CONTROL, 32'h8000_0000 | N);
        rate <= 1'b1;
        repeat (3) @(posedge clk);
        check("dfe at rate", 1, dfe);
        rate <= 1'b0;
        repeat (3) @(posedge clk);
        check("dfe off rate", 0, dfe);
        @(posedge clk);
        lstart <= 1'b1;
        @(posedge clk);
        lstart <= 1'b0;
        n = 0;
        while (lto !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        expire(n, 40);
        check("lock timeout", 1, n >= N + 1 && n <= N + 3);
        lock <= 1'b1;
        ev(3, 1);
        repeat (N + 8) @(posedge clk);
        check("lock reached", 0, lto);
        rd(`OFS_STATUS, 32'h42);
        $display("test lock timer done");
        bus(1'b1, `OFS_IDLE_PERIOD, 32'h40);
        act <= 1'b1;
        sbs <= 1'b1;
        repeat (1000) @(posedge clk);
        check("unplug live", 0, nunp);
        sbs <= 1'b0;
        repeat (300) @(posedge clk);
        check("unplug quiet", 1, nunp);
        sbs <= 1'b1;
        repeat (200) @(posedge clk);
        stp <= 1'b1;
        sbs <= 1'b0;
        repeat (500) @(posedge clk);
        check("unplug training", 1, nunp);
        stp <= 1'b0;
        act <= 1'b0;
        repeat (300) @(posedge clk);
        check("unplug stopped", 2, nunp);
        $display("test unplug done");
        give_verdict();
    end
endmodule : sink_training_ctrl_tb
